// ==== fault_pin_sync.sv ====
// two-flop synchroniser for the asynchronous fault pin
// assumes the pin may change at any time relative to pclk
`timescale 1ns/1ps
`default_nettype none
module fault_pin_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin in, synchronised level out
    input wire logic pin,
    output logic level
);
    logic meta; // first stage, read only by the second

    // plain double flop, no logic between stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== pwm_fault_a_override_control.sv ====
// fault A override controller for a four-pair pwm output stage
// assumes generator outputs, period start and fault B come from pclk logic
//
// How it works
// - fault drives enabled pins to programmed levels
// - mode one means cycle-by-cycle fault handling
// - mode zero latches enabled pins until released
// - pair enable bit puts pair under fault
// - disabled pair ignores fault A completely
// - fault A wins over fault B
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_a_override_control
    import pwm_fault_a_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire pwm_fault_a_pkg::apb_req_t apb_req,
    output pwm_fault_a_pkg::apb_rsp_t apb_rsp,
    // fault pin, active high, asynchronous
    input wire logic fault_a_pin,
    // pwm generator side
    input wire logic [pwm_fault_a_pkg::PINS-1:0] gen_outputs,
    input wire logic period_start,
    input wire pwm_fault_a_pkg::fault_b_t fault_b,
    // pins and interrupt
    output logic [pwm_fault_a_pkg::PINS-1:0] pin_outputs,
    output logic irq
);
    import pwm_fault_a_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [15:0] fault_a_control;
        logic [EVENTS-1:0] status;
        logic [EVENTS-1:0] mask;
        logic latched;      // latched-mode override held
        logic cycle_hold;   // cycle-by-cycle override held
        logic fault_prev;   // previous synced pin, for edge detect
        logic [31:0] prdata;
        logic [PINS-1:0] pins;
    } state_t;

    state_t cur; // registered state
    state_t next_cur; // next state
    logic fault_level; // synchronised fault pin

    // pin passes two flops before anything looks at it
    fault_pin_sync sync_u (
        .pclk(pclk),
        .presetn(presetn),
        .pin(fault_a_pin),
        .level(fault_level)
    );

    // pin-level override choice for one pin
    function automatic logic pick(input logic a_on, input logic a_lvl,
                                  input logic b_on, input logic b_lvl,
                                  input logic gen);
        if (a_on) begin
            pick = a_lvl;
        end else if (b_on) begin
            pick = b_lvl;
        end else begin
            pick = gen;
        end
    endfunction

    // true for an address the slave decodes
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_FAULT_A_CONTROL) || (a == OFS_EVENT_STATUS) ||
                 (a == OFS_EVENT_MASK) || (a == OFS_FAULT_STATE);
    endfunction

    logic setup_ph; // apb setup cycle
    logic access_ph; // apb access cycle, always completes
    logic fault_rise; // synced pin went active
    logic override_a; // fault A override in force
    logic override_was; // override in force last cycle
    logic [PAIRS-1:0] pair_en; // pairs under fault A

    // combinational next state
    always_comb begin
        next_cur = cur;
        setup_ph = apb_req.psel && !apb_req.penable;
        access_ph = apb_req.psel && apb_req.penable;
        fault_rise = fault_level && !cur.fault_prev;
        pair_en = cur.fault_a_control[ENABLE_LSB +: PAIRS];
        override_was = cur.latched || cur.cycle_hold;
        next_cur.fault_prev = fault_level;

        // software writes take effect in the access cycle
        if (access_ph && apb_req.pwrite) begin
            case (apb_req.paddr)
                OFS_FAULT_A_CONTROL: begin
                    // reserved bits 6..4 stay zero
                    next_cur.fault_a_control =
                        apb_req.pwdata[15:0] & CONTROL_WRITABLE;
                end
                OFS_EVENT_MASK: begin
                    next_cur.mask = apb_req.pwdata[EVENTS-1:0];
                end
                default: begin
                    // status is read-only; state writes only carry the release bit
                end
            endcase
        end

        // read data captured in setup, ready in access
        if (setup_ph) begin
            case (apb_req.paddr)
                OFS_FAULT_A_CONTROL: begin
                    next_cur.prdata = {16'h0000, cur.fault_a_control};
                end
                OFS_EVENT_STATUS: begin
                    next_cur.prdata = {30'h00000000, cur.status};
                end
                OFS_EVENT_MASK: begin
                    next_cur.prdata = {30'h00000000, cur.mask};
                end
                OFS_FAULT_STATE: begin
                    next_cur.prdata = {29'h00000000, cur.cycle_hold,
                                       cur.latched, fault_level};
                end
                default: begin
                    // unmapped reads as zero with an error
                    next_cur.prdata = 32'h00000000;
                end
            endcase
        end

        // read of status clears it; events below still win
        if (access_ph && !apb_req.pwrite &&
            apb_req.paddr == OFS_EVENT_STATUS) begin
            next_cur.status = EVENT_RESET;
        end

        if (cur.fault_a_control[MODE_BIT]) begin
            // cycle mode: hold while asserted, drop at period start
            next_cur.latched = 1'b0;
            if (fault_level) begin
                next_cur.cycle_hold = 1'b1;
            end else if (period_start) begin
                next_cur.cycle_hold = 1'b0;
            end
        end else begin
            // latched mode: only a release write with pin idle ends it
            next_cur.cycle_hold = 1'b0;
            if (fault_level) begin
                next_cur.latched = 1'b1;
            end else if (access_ph && apb_req.pwrite &&
                         apb_req.paddr == OFS_FAULT_STATE &&
                         apb_req.pwdata[REL_BIT]) begin
                next_cur.latched = 1'b0;
            end
        end

        override_a = next_cur.latched || next_cur.cycle_hold;

        // sticky events, set wins over read clear
        if (fault_rise) begin
            next_cur.status[EV_FAULT_SET] = 1'b1;
        end
        if (override_was && !override_a) begin
            next_cur.status[EV_FAULT_DONE] = 1'b1;
        end

        // per pin: fault A over fault B over generator
        for (int i = 0; i < PINS; i++) begin
            next_cur.pins[i] = pick(
                override_a && pair_en[i/2],
                cur.fault_a_control[LEVELS_LSB + i],
                fault_b.active[i/2], fault_b.levels[i],
                gen_outputs[i]);
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{fault_a_control: CONTROL_RESET, status: EVENT_RESET,
                     mask: EVENT_RESET, latched: 1'b0, cycle_hold: 1'b0,
                     fault_prev: 1'b0, prdata: 32'h00000000,
                     pins: {PINS{1'b0}}};
        end else begin
            cur <= next_cur;
        end
    end

    // outputs; zero wait states keep the slave simple
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
                             !mapped(apb_req.paddr);
    assign apb_rsp.prdata = cur.prdata;
    assign pin_outputs = cur.pins;
    assign irq = |(cur.status & cur.mask);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // an enabled pin sits at its programmed level while the fault lasts
    fault_level_a: assert property (
        fault_level && cur.fault_a_control[0] && !$rose(fault_level)
        |=> pin_outputs[0] == $past(cur.fault_a_control[LEVELS_LSB]))
        else $error("pair 1 pin not at fault level");

    // cycle mode holds with the pin high and never uses the latch
    cycle_hold_a: assert property (
        cur.fault_a_control[MODE_BIT] && fault_level |=> cur.cycle_hold
        && !cur.latched)
        else $error("cycle mode did not hold override");

    // only a bus write may end a latched override
    latch_keep_a: assert property (
        !cur.fault_a_control[MODE_BIT] && cur.latched && !fault_level
        && !(apb_req.psel && apb_req.penable && apb_req.pwrite)
        && !$changed(cur.fault_a_control[MODE_BIT]) |=> cur.latched)
        else $error("latch dropped without release");

    // next-state latch, so a release in the same cycle is not counted
    pair_enable_a: assert property (
        next_cur.latched && cur.fault_a_control[3] |=>
        pin_outputs[7:6] == $past(cur.fault_a_control[15:14]))
        else $error("enabled pair 4 not overridden");

    // a pair outside both faults just follows the generator
    pair_free_a: assert property (
        !cur.fault_a_control[1] && !fault_b.active[1]
        ##1 !$past(cur.fault_a_control[1]) |->
        pin_outputs[3:2] == $past(gen_outputs[3:2]))
        else $error("disabled pair 2 touched by fault");

    // levels come from the control word of the cycle before
    a_over_b_a: assert property (
        (cur.latched || cur.cycle_hold) && fault_b.active[0]
        && cur.fault_a_control[0] && $stable(cur.fault_a_control)
        ##1 ($past(cur.latched) && cur.latched) |->
        pin_outputs[1:0] == $past(cur.fault_a_control[9:8]))
        else $error("fault B overrode fault A");

    // no period start means the cycle override stays put
    period_release_a: assert property (
        cur.fault_a_control[MODE_BIT] && cur.cycle_hold && !fault_level
        && !period_start && !$changed(cur.fault_a_control)
        |=> cur.cycle_hold)
        else $error("cycle override dropped before period start");

    // the event bit lands one edge after the rise; a status read
    // in that window may clear it again, so look only at that edge
    event_irq_a: assert property (
        $rose(fault_level) && cur.mask[EV_FAULT_SET]
        && next_cur.mask[EV_FAULT_SET] |=> irq)
        else $error("fault event did not raise interrupt");

    // latched mode grabs the override as soon as the synced pin is high
    latch_set_a: assert property (
        !cur.fault_a_control[MODE_BIT] && fault_level
        |=> cur.latched && !cur.cycle_hold)
        else $error("latched mode did not latch");

    // a release write only counts once the pin has gone quiet
    release_drop_a: assert property (
        !cur.fault_a_control[MODE_BIT] && !fault_level && access_ph
        && apb_req.pwrite && apb_req.paddr == OFS_FAULT_STATE
        && apb_req.pwdata[REL_BIT] |=> !cur.latched)
        else $error("release write did not free the latch");

    // pair 2 left out of fault A still follows fault B
    pair_b_keep_a: assert property (
        !cur.fault_a_control[1] && fault_b.active[1]
        |=> pin_outputs[3:2] == $past(fault_b.levels[3:2]))
        else $error("disabled pair 2 lost its fault B levels");

    // first period start with the pin quiet ends the cycle override
    cycle_drop_a: assert property (
        cur.fault_a_control[MODE_BIT] && cur.cycle_hold && !fault_level
        && period_start |=> !cur.cycle_hold)
        else $error("cycle override kept past period start");

    // with no override pending the generator owns pair 4 again
    gen_return_a: assert property (
        cur.fault_a_control[MODE_BIT] && !next_cur.cycle_hold
        && !fault_b.active[3]
        |=> pin_outputs[7:6] == $past(gen_outputs[7:6]))
        else $error("pair 4 not back on the generator");

    // the end of an override is recorded, even against a status read
    done_event_a: assert property (
        (cur.latched || cur.cycle_hold) && !next_cur.latched
        && !next_cur.cycle_hold |=> cur.status[EV_FAULT_DONE])
        else $error("override end not recorded");

    // a fault edge is recorded, even against a status read
    rise_event_a: assert property (
        $rose(fault_level) |=> cur.status[EV_FAULT_SET])
        else $error("fault edge not recorded");

    // a status read with nothing new arriving leaves it empty
    read_clear_a: assert property (
        access_ph && !apb_req.pwrite && apb_req.paddr == OFS_EVENT_STATUS
        && !fault_rise && !(override_was && !override_a)
        |=> cur.status == EVENT_RESET)
        else $error("status read did not clear");
endmodule
`default_nettype wire

// ==== pwm_fault_a_pkg.sv ====
// constants and carrier types for the fault A override controller
// assumes a 32-bit apb slave and an 8-pin, 4-pair pwm output stage
package pwm_fault_a_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_FAULT_A_CONTROL = 8'h00;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h08;
    localparam logic [7:0] OFS_FAULT_STATE = 8'h0C;
    // fault_a_control fields
    localparam int LEVELS_LSB = 8;
    localparam int MODE_BIT = 7;
    localparam int ENABLE_LSB = 0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WRITABLE = 16'hFF8F;
    // event bits in status and mask
    localparam int EV_FAULT_SET = 0;
    localparam int EV_FAULT_DONE = 1;
    localparam int EVENTS = 2;
    localparam logic [1:0] EVENT_RESET = 2'h0;
    // fault_state readback fields and release strobe bit
    localparam int ST_PIN = 0;
    localparam int ST_LATCHED = 1;
    localparam int ST_CYCLE = 2;
    localparam int REL_BIT = 0;
    // output geometry
    localparam int PAIRS = 4;
    localparam int PINS = 8;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // fault B request from the neighbouring controller
    typedef struct packed {
        logic [PAIRS-1:0] active;
        logic [PINS-1:0] levels;
    } fault_b_t;
endpackage

// ==== pwm_side_model.sv ====
// far side model: fault A source, pwm generator, fault B neighbour
// assumes the bench steps its controls just after rising edges
`timescale 1ns/1ps
`default_nettype none
module pwm_side_model
    import pwm_fault_a_pkg::*;
#(
    parameter int PERIOD = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controls from the bench
    input wire logic fault_req,
    input wire logic periods_on,
    input wire pwm_fault_a_pkg::fault_b_t b_req,
    // towards the design
    output logic fault_a_pin,
    output logic [pwm_fault_a_pkg::PINS-1:0] gen_outputs,
    output logic period_start,
    output pwm_fault_a_pkg::fault_b_t fault_b
);
    int cnt; // position in the period
    // period pulse; pattern flips each period so stale levels show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            period_start <= 1'b0;
            gen_outputs <= 8'h5A;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            period_start <= periods_on && (cnt == PERIOD - 1);
            if (periods_on && cnt == PERIOD - 1) begin
                gen_outputs <= ~gen_outputs;
            end
        end
    end
    // pin and fault B follow the bench directly
    assign fault_a_pin = fault_req;
    assign fault_b = b_req;
endmodule
`default_nettype wire

// ==== test_pwm_fault_a_override_control.sv ====
// bench: apb register tests and fault A override scenarios
// assumes pwm_side_model drives the generator side
`timescale 1ns/1ps
`default_nettype none
module test_pwm_fault_a_override_control;
    import pwm_fault_a_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic fault_req = 1'b0;
    logic periods_on = 1'b0;
    fault_b_t b_req = '0;
    logic fault_a_pin, period_start, irq, err;
    logic [PINS-1:0] gen_outputs, pin_outputs;
    fault_b_t fault_b;
    logic [31:0] rd;
    logic [15:0] c; // control value in force
    int n_mismatch = 0;
    int n_tests = 0;
    always #50 pclk = ~pclk;
    pwm_side_model #(.PERIOD(16)) side_u (.pclk(pclk), .presetn(presetn),
        .fault_req(fault_req), .periods_on(periods_on), .b_req(b_req),
        .fault_a_pin(fault_a_pin), .gen_outputs(gen_outputs),
        .period_start(period_start), .fault_b(fault_b));
    pwm_fault_a_override_control dut_u (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .fault_a_pin(fault_a_pin),
        .gen_outputs(gen_outputs), .period_start(period_start),
        .fault_b(fault_b), .pin_outputs(pin_outputs), .irq(irq));
    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // one apb transfer; pready polled under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            end_sim();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, e, rd);
    endtask
    // expected pins: fault A first, then fault B, then generator
    function automatic logic [7:0] exp_pins(input logic on);
        logic [7:0] e;
        for (int i = 0; i < PINS; i++) begin
            if (on && c[ENABLE_LSB + i / 2]) e[i] = c[LEVELS_LSB + i];
            else if (fault_b.active[i / 2]) e[i] = fault_b.levels[i];
            else e[i] = gen_outputs[i];
        end
        return e;
    endfunction
    task automatic pins(input logic on, input int wait_n);
        repeat (wait_n) @(posedge pclk);
        chk("pin_outputs", {24'h0, exp_pins(on)}, {24'h0, pin_outputs});
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("control", OFS_FAULT_A_CONTROL, 32'h0);
        rdchk("status", OFS_EVENT_STATUS, 32'h0);
        rdchk("mask", OFS_EVENT_MASK, 32'h0);
        rdchk("state", OFS_FAULT_STATE, 32'h0);
        chk("pslverr", 32'h0, {31'h0, err});
        rdchk("unmapped", 8'h10, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, OFS_FAULT_A_CONTROL, 32'hFFFFFFFF);
        rdchk("control", OFS_FAULT_A_CONTROL, 32'h0000FF8F);
        $display("test registers done");
        // latched mode, pairs 1, 3 and 4, fault B on pairs 1 and 2
        b_req <= '{active:4'b0011, levels:8'hF0};
        c = 16'hC30D;
        apb(1'b1, OFS_FAULT_A_CONTROL, {16'h0, c});
        pins(1'b0, 3);
        fault_req <= 1'b1;
        pins(1'b1, 6);
        chk("irq", 32'h0, {31'h0, irq});
        fault_req <= 1'b0;
        periods_on <= 1'b1;
        repeat (40) @(posedge pclk);
        periods_on <= 1'b0;
        pins(1'b1, 3);
        rdchk("state", OFS_FAULT_STATE, 32'h2);
        apb(1'b1, OFS_EVENT_MASK, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("status", OFS_EVENT_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_FAULT_STATE, 32'h1);
        pins(1'b0, 3);
        rdchk("status", OFS_EVENT_STATUS, 32'h2);
        $display("test latched done");
        // cycle mode, all pairs, fault A over fault B
        c = 16'h3C8F;
        apb(1'b1, OFS_FAULT_A_CONTROL, {16'h0, c});
        fault_req <= 1'b1;
        pins(1'b1, 6);
        periods_on <= 1'b1;
        repeat (20) @(posedge pclk);
        periods_on <= 1'b0;
        pins(1'b1, 3);
        fault_req <= 1'b0;
        pins(1'b1, 8);
        rdchk("state", OFS_FAULT_STATE, 32'h4);
        periods_on <= 1'b1;
        repeat (20) @(posedge pclk);
        periods_on <= 1'b0;
        pins(1'b0, 3);
        rdchk("status", OFS_EVENT_STATUS, 32'h3);
        $display("test cycle done");
        end_sim();
    end
endmodule
`default_nettype wire
